// >>> hdl/tla_arbiter.sv
/*
 two-level interrupt arbiter: priority bits, per-cycle decode,
 preemption, tie break and call timing toward the core.
 assumes the core pulses instr_done_i at each instruction end and
 return_from_interrupt_i as the return-from-interrupt instruction completes; all
 inputs come from logic on sys_clk_i.
*/
// Behaviour
// - every source owns a writable bit choosing low or high level.
// - a pending high request preempts a running low routine.
// - a running high routine is never preempted.
// - after reset all sources sit at low priority.
// - of simultaneous requests the higher level wins.
// - same-level ties use a fixed hardwired source order.
// - requests are sampled and decoded every clock cycle.
// - best response is one detect cycle plus a four-cycle call.
// - after a return one more instruction runs before the next call.
// - worst response is 18 cycles: detect, return, divide, call.
// - an equal or higher running routine holds off a new request.
// - the core ends any instruction within eight cycles.
module tla_arbiter
#(
   parameter int N = tla_pkg::N_SRC
)
(
   input  wire logic                          sys_clk_i,
   input  wire logic                          reset_n_i,
   input  wire logic [N-1:0]                  pend_i,
   input  wire logic [N-1:0]                  enable_i,
   input  wire logic                          prio_wr_i,
   input  wire logic [N-1:0]                  prio_wdata_i,
   input  wire logic                          instr_done_i,
   input  wire logic                          return_from_interrupt_i,
   output logic [N-1:0]                       prio_o,
   output logic                               call_o,
   output logic                               call_busy_o,
   output logic [$clog2(N)-1:0]               call_src_o,
   output logic                               in_low_o,
   output logic                               in_high_o
);

   // refuse widths the decode cannot serve
   if (N < 2 || N > tla_pkg::N_SRC)
   begin : g_bad_n
      $error("tla_arbiter: N out of range");
   end

   localparam int SW = $clog2(N);

   tla_pkg::tla_state_e  state;
   tla_pkg::tla_state_e  next_state;
   logic [N-1:0]         prio;
   logic [N-1:0]         next_prio;
   logic [N-1:0]         req;
   logic [N-1:0]         next_req;
   logic                 in_low;
   logic                 next_in_low;
   logic                 in_high;
   logic                 next_in_high;
   logic [2:0]           cnt;
   logic [2:0]           next_cnt;
   logic [SW-1:0]        src;
   logic [SW-1:0]        next_src;
   logic                 call;
   logic                 next_call;
   tla_pkg::tla_grant_s  win;
   // call in progress, held in a flop for the output
   logic                 busy;
   logic                 next_busy;
   // winner may enter this cycle
   logic                 accept;

   // priority bits, one per source
   always_comb
   begin
      next_prio = prio;
      if (prio_wr_i)
         next_prio = prio_wdata_i;
   end

   // winner of the registered request set
   always_comb
   begin
      win = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i] && !prio[i] && !(win.active && win.high))
         begin
            win.active = 1'b1;
            win.src    = tla_pkg::SRC_W'(i);
         end
      end
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i] && prio[i])
         begin
            win.active = 1'b1;
            win.high   = 1'b1;
            win.src    = tla_pkg::SRC_W'(i);
         end
      end
   end

   // entry only at an instruction boundary
   always_comb
   begin
      accept = 1'b0;
      if (win.active && instr_done_i)
      begin
         if (!in_high)
            accept = win.high || !in_low;
      end
   end

   always_comb
   begin
      next_req     = pend_i & enable_i;
      next_state   = state;
      next_in_low  = in_low;
      next_in_high = in_high;
      next_cnt     = cnt;
      next_src     = src;
      next_call    = 1'b0;
      unique case (state)
         tla_pkg::ST_IDLE:
         begin
            if (accept)
            begin
               next_state = tla_pkg::ST_CALL;
               next_src   = SW'(win.src);
               next_cnt   = '0;
            end
         end
         tla_pkg::ST_CALL:
         begin
            next_cnt = cnt + 3'd1;
            if (cnt == tla_pkg::CALL_LAST)
            begin
               next_call  = 1'b1;
               next_state = tla_pkg::ST_IDLE;
               if (prio[src])
                  next_in_high = 1'b1;
               else
                  next_in_low = 1'b1;
            end
         end
         tla_pkg::ST_HOLD:
         begin
            // the one instruction after a return ends here
            if (accept)
            begin
               next_state = tla_pkg::ST_CALL;
               next_src   = SW'(win.src);
               next_cnt   = '0;
            end
            else if (instr_done_i)
            begin
               next_state = tla_pkg::ST_IDLE;
            end
         end
         default:
            next_state = tla_pkg::ST_IDLE;
      endcase
      if (return_from_interrupt_i && state != tla_pkg::ST_CALL)
      begin
         // return leaves the innermost level
         if (in_high)
            next_in_high = 1'b0;
         else
            next_in_low = 1'b0;
         next_state = tla_pkg::ST_HOLD;
      end
      next_busy = (next_state == tla_pkg::ST_CALL);
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         state   <= tla_pkg::ST_IDLE;
         prio    <= tla_pkg::PRIO_RESET[N-1:0];
         req     <= '0;
         in_low  <= 1'b0;
         in_high <= 1'b0;
         cnt     <= '0;
         src     <= '0;
         call    <= 1'b0;
         busy    <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         prio    <= next_prio;
         req     <= next_req;
         in_low  <= next_in_low;
         in_high <= next_in_high;
         cnt     <= next_cnt;
         src     <= next_src;
         call    <= next_call;
         busy    <= next_busy;
      end
   end

   assign prio_o      = prio;
   assign call_o      = call;
   assign call_busy_o = busy;
   assign call_src_o  = src;
   assign in_low_o    = in_low;
   assign in_high_o   = in_high;

endmodule // tla_arbiter

// >>> hdl/tla_pkg.sv
/*
 package of the two-level interrupt arbiter: widths, timing counts,
 state codes and the grant carrier of the winner decode.
 assumes a single 200 MHz system clock and a synchronous core reset.
*/
package tla_pkg;

   localparam int N_SRC          = 8;
   localparam int SRC_W          = $clog2(N_SRC);
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int DETECT_CYC     = 1;
   localparam int CALL_CYC       = 4;
   localparam int BEST_RESP_CYC  = 5;
   localparam int WORST_RESP_CYC = 18;
   localparam int MAX_INSTR_CYC  = 8;
   localparam int CNT_W          = 3;
   localparam logic [CNT_W-1:0] CALL_LAST =
      CNT_W'(CALL_CYC - 1);
   localparam logic [N_SRC-1:0] PRIO_RESET = 8'h00;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_CALL = 2'b01,
      ST_HOLD = 2'b11
   } tla_state_e;

   typedef struct packed
   {
      logic             active;
      logic             high;
      logic [SRC_W-1:0] src;
   } tla_grant_s;

endpackage

// >>> verification/tla_core_model.sv
/*
 core model: instruction end pulses every gap_i cycles, return on request.
 assumes gap_i of 1 to 8 and ret_i driven at the falling edge.
*/
module tla_core_model
(
   input  wire logic       sys_clk_i,
   input  wire logic [3:0] gap_i,
   input  wire logic       ret_i,
   output logic            instr_done_o,
   output logic            return_from_interrupt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   always @(posedge sys_clk_i)
   begin
      cnt <= (cnt + 4'h1 >= gap_i) ? 4'h0 : cnt + 4'h1;
   end
   assign instr_done_o = (cnt == 4'h0);
   assign return_from_interrupt_o       = ret_i & instr_done_o;
endmodule // tla_core_model

// >>> verification/tla_arbiter_checker.sv
/*
 port checker of the arbiter.
 assumes it is bound into tla_arbiter.
*/
module tla_arbiter_checker
#(
   parameter int N = tla_pkg::N_SRC
)
(
   input wire logic         sys_clk_i,
   input wire logic         reset_n_i,
   input wire logic         prio_wr_i,
   input wire logic [N-1:0] prio_wdata_i,
   input wire logic         return_from_interrupt_i,
   input wire logic [N-1:0] prio_o,
   input wire logic         call_o,
   input wire logic         call_busy_o,
   input wire logic         in_low_o,
   input wire logic         in_high_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   busy_len_a: assert property ($rose(call_busy_o) |->
      call_busy_o[*4] ##1 (call_o && !call_busy_o)) else $error("call len");
   call_mark_a: assert property (call_o |-> in_low_o || in_high_o)
      else $error("no routine");
   high_keep_a: assert property (in_high_o |-> !$rose(call_busy_o))
      else $error("high preempted");
   preempt_a: assert property ($rose(call_busy_o) && in_low_o |->
      ##4 (call_o && in_high_o)) else $error("bad preempt");
   prio_wr_a: assert property (prio_wr_i |=>
      prio_o == $past(prio_wdata_i)) else $error("prio write");
   prio_keep_a: assert property (!prio_wr_i |=> $stable(prio_o))
      else $error("prio drift");
   reset_val_a: assert property (disable iff (1'b0) !reset_n_i |=>
      prio_o == '0 && !in_low_o && !in_high_o) else $error("reset");
   ret_hold_a: assert property (return_from_interrupt_i && !call_busy_o |=>
      !call_busy_o) else $error("call after return");
   cover property ($rose(call_busy_o));
   cover property (call_o && in_high_o);
   cover property (return_from_interrupt_i && in_low_o);
endmodule // tla_arbiter_checker

bind tla_arbiter tla_arbiter_checker #(.N(N)) chk_i (.sys_clk_i,
   .reset_n_i, .prio_wr_i, .prio_wdata_i, .return_from_interrupt_i, .prio_o, .call_o,
   .call_busy_o, .in_low_o, .in_high_o);

// >>> verification/testbench.sv
/*
 testbench of the arbiter with a core model.
 assumes 8 sources and a 200 MHz clock.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk_i = 0, reset_n_i = 0, prio_wr_i = 0, ret = 0;
   logic [7:0] pend_i = 0, enable_i = 8'hff, prio_wdata_i = 0, prio_o;
   logic [3:0] gap = 4'h1;
   logic       instr_done_i, return_from_interrupt_i, call_o, call_busy_o, in_low_o;
   logic       in_high_o;
   logic [2:0] call_src_o;
   int         fail_count = 0, total_checks = 0, cyc = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   tla_arbiter DUT (.sys_clk_i, .reset_n_i, .pend_i, .enable_i, .prio_wr_i,
      .prio_wdata_i, .instr_done_i, .return_from_interrupt_i, .prio_o, .call_o,
      .call_busy_o, .call_src_o, .in_low_o, .in_high_o);
   tla_core_model core (.sys_clk_i, .gap_i(gap), .ret_i(ret),
      .instr_done_o(instr_done_i), .return_from_interrupt_o(return_from_interrupt_i));
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         final_report();
      end
   end
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      total_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic irq(logic [7:0] p, logic [7:0] s, output int n);
      logic [2:0] k;
      @(negedge sys_clk_i) pend_i = p;
      n = 0;
      do
      begin
         @(posedge sys_clk_i) #1 n++;
      end while (!call_o && n < 40);
      if (call_o)
      begin
         k = call_src_o;
         chk("src", 8'(k), s);
         @(negedge sys_clk_i) pend_i[k] = 0;
      end
   endtask
   task automatic ret_call();
      @(negedge sys_clk_i) ret = 1;
      @(posedge sys_clk_i) while (!return_from_interrupt_i) @(posedge sys_clk_i);
      @(negedge sys_clk_i) ret = 0;
   endtask
   task automatic t_pri();
      chk("prio", prio_o, 8'h00);
      @(negedge sys_clk_i) {prio_wr_i, prio_wdata_i} = {1'b1, 8'h40};
      @(negedge sys_clk_i) prio_wr_i = 0;
      chk("prio", prio_o, 8'h40);
      $display("t_pri done");
   endtask
   task automatic t_best();
      int n;
      irq(8'h0a, 8'h01, n);
      chk("lat", 8'(n), 8'(tla_pkg::BEST_RESP_CYC + 1));
      ret_call();
      irq(8'h08, 8'h03, n);
      chk("ret", 8'(n), 8'(tla_pkg::CALL_CYC));
      ret_call();
      $display("t_best done");
   endtask
   task automatic t_pre();
      int n;
      irq(8'h20, 8'h05, n);
      irq(8'h42, 8'h06, n);
      chk("high", 8'(in_high_o), 8'h01);
      ret_call();
      irq(8'h02, 8'h01, n);
      chk("held", 8'(n), 8'h28);
      gap = 4'h8;
      ret_call();
      irq(8'h02, 8'h01, n);
      chk("worst", 8'(n), 8'(tla_pkg::MAX_INSTR_CYC + tla_pkg::CALL_CYC - 1));
      ret_call();
      $display("t_pre done");
   endtask
   task automatic t_en();
      int n;
      enable_i = 8'hfd;
      irq(8'h02, 8'h01, n);
      chk("masked", 8'(n), 8'h28);
      @(negedge sys_clk_i) enable_i = 8'hff;
      irq(8'h02, 8'h01, n);
      ret_call();
      $display("t_en done");
   endtask
   initial
   begin
      repeat (5) @(negedge sys_clk_i);
      reset_n_i = 1;
      t_pri();
      t_best();
      t_pre();
      t_en();
      final_report();
   end
endmodule // testbench
